// file: rtl/event_route_pkg.sv
// ============================================================================
// Event routing package
// ============================================================================
// Purpose: Shared sizes, reset values and state codes of the event router.
// Assumes: One clock; every register resets asynchronously on rst_n.
// Notes:   Index values count from one; zero means nothing was pending.
package event_route_pkg;

   // Default sizes of the fabric.
   localparam int DEF_NPUB   = 4;   // Publishers.
   localparam int DEF_NCOND  = 8;   // Conditions per publisher.
   localparam int DEF_NDMA   = 2;   // DMA route channels.
   localparam int DEF_NGEN   = 4;   // Generic route channels.
   localparam int DEF_NSPLIT = 2;   // Leading generic channels that split 1:2.

   // Reset values.
   localparam logic STATUS_RESET = 1'b0;
   localparam logic TRIG_RESET   = 1'b0;
   localparam logic REQ_RESET    = 1'b0;

   // Offset added to a condition number to form its pending index.
   localparam int IDX_BASE = 1;

   // Power handshake states of a route channel.
   typedef enum logic [1:0]
   {
      CH_IDLE = 2'b00,
      CH_REQ  = 2'b01,
      CH_FIRE = 2'b10
   } ch_state_t;

endpackage : event_route_pkg

// file: rtl/pub_status_if.sv
// ============================================================================
// Publisher status carrier
// ============================================================================
// Purpose: Carries one publisher's status and event to the routing fabric.
// Assumes: Every signal is driven from a flip-flop in the publisher.
// Notes:   irq is a level, evt a one-cycle pulse.
`timescale 1ns/1ps
interface pub_status_if #(parameter int NCOND = 8, parameter int IDXW = 4);
   logic [NCOND-1:0] raw;
   logic [NCOND-1:0] masked;
   logic [IDXW-1:0]  idx;
   logic             evt;
   logic             irq;

   modport src (output raw, output masked, output idx, output evt, output irq);
   modport dst (input raw, input masked, input idx, input evt, input irq);
endinterface : pub_status_if

// file: rtl/event_publisher.sv
// ============================================================================
// Event publisher register set
// ============================================================================
// Purpose: Raw, mask, masked, set, clear and pending index of one publisher.
// Assumes: hw_cond, sw_set, sw_clear and idx_rd are one-cycle pulses.
// Notes:   Condition 0 has the highest priority.
`timescale 1ns/1ps
module event_publisher
   import event_route_pkg::*;
#(
   parameter int NCOND = DEF_NCOND,
   parameter int IDXW  = 4
)
(
   input  wire logic             clk,
   input  wire logic             rst_n,
   input  wire logic [NCOND-1:0] hw_cond,
   input  wire logic [NCOND-1:0] mask,
   input  wire logic [NCOND-1:0] sw_set,
   input  wire logic [NCOND-1:0] sw_clear,
   input  wire logic             idx_rd,
   pub_status_if.src             bus
);
   // The index must hold every condition number as well as the empty code.
   if ((1 << IDXW) < NCOND + IDX_BASE)
   begin : g_bad_idxw
      $error("index width too narrow for the condition count");
   end

   typedef struct packed
   {
      logic [NCOND-1:0] raw;
      logic [NCOND-1:0] masked;
      logic [IDXW-1:0]  idx;
      logic             evt;
      logic             irq;
   } pub_state_t;

   pub_state_t st;
   pub_state_t next_st;

   // ==========================================================================
   // Next state
   // ==========================================================================
   // Setters are ORed in last so a condition arriving with a clear survives.
   always_comb
   begin
      logic [IDXW-1:0]  pick;
      logic [NCOND-1:0] hit;
      next_st = st;
      pick    = '0;
      hit     = '0;
      for (int i = NCOND - 1; i >= 0; i--)
      begin
         if (st.masked[i])
         begin
            pick   = IDXW'(i + IDX_BASE);
            hit    = '0;
            hit[i] = 1'b1;
         end
      end
      if (idx_rd)
      begin
         next_st.idx = pick;
      end
      next_st.raw    = (st.raw & ~sw_clear & ~(idx_rd ? hit : '0))
                       | hw_cond | sw_set;
      next_st.masked = next_st.raw & mask;
      next_st.evt    = |(next_st.masked & ~st.masked);
      next_st.irq    = |next_st.masked;
   end

   // State register.
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         st <= '{raw: {NCOND{STATUS_RESET}}, masked: {NCOND{STATUS_RESET}},
                 idx: '0, evt: TRIG_RESET, irq: TRIG_RESET};
      end
      else
      begin
         st <= next_st;
      end
   end

   assign bus.raw    = st.raw;
   assign bus.masked = st.masked;
   assign bus.idx    = st.idx;
   assign bus.evt    = st.evt;
   assign bus.irq    = st.irq;

   // A read with nothing pending must answer zero.
   chk_empty_index: assert property (@(posedge clk) disable iff (!rst_n)
      (idx_rd && st.masked == '0) |=> st.idx == '0)
      else $error("index read with nothing pending returned nonzero");

endmodule : event_publisher

// file: rtl/route_channel.sv
// ============================================================================
// Route channel with power handshake
// ============================================================================
// Purpose: Delivers a routed event as a trigger once power and clock are up.
// Assumes: The power and clock unit holds pwr_ack high while the domain is up.
// Notes:   Events that arrive while a delivery is in flight coalesce into one.
`timescale 1ns/1ps
module route_channel
   import event_route_pkg::*;
#(
   parameter bit SPLIT = 1'b0
)
(
   input  wire logic clk,
   input  wire logic rst_n,
   input  wire logic evt,
   input  wire logic pwr_ack,
   output logic      pwr_req,
   output logic      trig_a,
   output logic      trig_b
);
   typedef struct packed
   {
      ch_state_t st;
      logic      pend;
      logic      req;
      logic      ta;
      logic      tb;
   } ch_reg_t;

   ch_reg_t s;
   ch_reg_t next_s;

   // ==========================================================================
   // Handshake sequencer
   // ==========================================================================
   // No trigger leaves before the power unit has answered the request.
   always_comb
   begin
      next_s      = s;
      next_s.ta   = 1'b0;
      next_s.tb   = 1'b0;
      next_s.pend = s.pend | evt;
      case (s.st)
         CH_IDLE:
         begin
            if (s.pend || evt)
            begin
               next_s.st   = CH_REQ;
               next_s.req  = 1'b1;
               next_s.pend = 1'b0;
            end
         end
         CH_REQ:
         begin
            if (pwr_ack)
            begin
               next_s.st = CH_FIRE;
               next_s.ta = 1'b1;
               next_s.tb = SPLIT;
            end
         end
         CH_FIRE:
         begin
            next_s.st  = CH_IDLE;
            next_s.req = 1'b0;
         end
         default:
         begin
            next_s.st  = CH_IDLE;
            next_s.req = 1'b0;
         end
      endcase
   end

   // State register.
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         s <= '{st: CH_IDLE, pend: 1'b0, req: REQ_RESET, ta: TRIG_RESET, tb: TRIG_RESET};
      end
      else
      begin
         s <= next_s;
      end
   end

   assign pwr_req = s.req;
   assign trig_a  = s.ta;
   assign trig_b  = s.tb;

   chk_power_first: assert property (@(posedge clk) disable iff (!rst_n)
      trig_a |-> $past(pwr_req) && $past(pwr_ack))
      else $error("trigger issued without a granted power request");

   chk_ack_fires: assert property (@(posedge clk) disable iff (!rst_n)
      (s.st == CH_REQ && pwr_ack) |=> trig_a ##1 !trig_a)
      else $error("granted request did not give a single trigger");

   chk_split_pair: assert property (@(posedge clk) disable iff (!rst_n)
      trig_b == (SPLIT && trig_a))
      else $error("second subscriber trigger does not match channel form");

   chk_event_served: assert property (@(posedge clk) disable iff (!rst_n)
      evt |-> ##[1:2] pwr_req)
      else $error("routed event did not raise a power request");

endmodule : route_channel

// file: rtl/event_route_manager.sv
// ============================================================================
// Event route manager
// ============================================================================
// Purpose: Carries publisher events to CPU, DMA and peripheral subscribers.
// Assumes: All inputs are synchronous to clk; selects are static while used.
// Notes:   A select of zero, or above the publisher count, leaves a channel off.
`timescale 1ns/1ps
module event_route_manager
   import event_route_pkg::*;
#(
   parameter int NPUB   = DEF_NPUB,
   parameter int NCOND  = DEF_NCOND,
   parameter int NDMA   = DEF_NDMA,
   parameter int NGEN   = DEF_NGEN,
   parameter int NSPLIT = DEF_NSPLIT,
   parameter int SELW   = $clog2(NPUB + 1),
   parameter int IDXW   = $clog2(NCOND + 1)
)
(
   input  wire logic                             clk,
   input  wire logic                             rst_n,
   input  wire logic [NPUB-1:0][NCOND-1:0]       hw_cond,
   input  wire logic [NPUB-1:0][NCOND-1:0]       condition_mask,
   input  wire logic [NPUB-1:0][NCOND-1:0]       software_event_set,
   input  wire logic [NPUB-1:0][NCOND-1:0]       software_event_clear,
   input  wire logic [NPUB-1:0]                  index_read,
   input  wire logic [NDMA-1:0][SELW-1:0]        dma_sel,
   input  wire logic [NGEN-1:0][SELW-1:0]        gen_sel,
   input  wire logic [NDMA+NGEN-1:0]             pwr_ack,
   output logic      [NPUB-1:0][NCOND-1:0]       raw_event_status,
   output logic      [NPUB-1:0][NCOND-1:0]       masked_event_status,
   output logic      [NPUB-1:0][IDXW-1:0]        pending_index_reader,
   output logic      [NPUB-1:0]                  cpu_irq,
   output logic      [NDMA-1:0]                  dma_trig,
   output logic      [NGEN-1:0]                  gen_trig_a,
   output logic      [NGEN-1:0]                  gen_trig_b,
   output logic      [NDMA+NGEN-1:0]             pwr_req
);
   localparam int NCH = NDMA + NGEN;

   // ==========================================================================
   // Elaboration checks
   // ==========================================================================
   // The select and index widths must hold every publisher and condition.
   if (NPUB < 1 || NCOND < 1 || NDMA < 1 || NGEN < 1)
   begin : g_bad_size
      $error("event router needs at least one of each element");
   end
   if (NSPLIT < 0 || NSPLIT > NGEN)
   begin : g_bad_split
      $error("splitter channel count exceeds generic channel count");
   end
   if ((1 << SELW) < NPUB + 1 || (1 << IDXW) < NCOND + 1)
   begin : g_bad_width
      $error("select or index width too narrow");
   end

   // ==========================================================================
   // Publishers
   // ==========================================================================
   pub_status_if #(.NCOND(NCOND), .IDXW(IDXW)) pub [NPUB] ();

   logic [NPUB-1:0] pub_evt;

   // Each publisher keeps its own six-register set; its interrupt line is the
   // fixed processor route and needs no select or power handshake.
   for (genvar p = 0; p < NPUB; p++)
   begin : g_pub
      event_publisher #(
         .NCOND (NCOND),
         .IDXW  (IDXW)
      ) u_pub (
         .clk      (clk),
         .rst_n    (rst_n),
         .hw_cond  (hw_cond[p]),
         .mask     (condition_mask[p]),
         .sw_set   (software_event_set[p]),
         .sw_clear (software_event_clear[p]),
         .idx_rd   (index_read[p]),
         .bus      (pub[p])
      );

      assign raw_event_status[p]     = pub[p].raw;
      assign masked_event_status[p]  = pub[p].masked;
      assign pending_index_reader[p] = pub[p].idx;
      assign pub_evt[p]              = pub[p].evt;
      assign cpu_irq[p]              = pub[p].irq;
   end

   // ==========================================================================
   // Programmable route selection
   // ==========================================================================
   // DMA channels come first in the channel list, generic channels after them.
   logic [NCH-1:0][SELW-1:0] ch_sel;

   for (genvar c = 0; c < NCH; c++)
   begin : g_sel
      if (c < NDMA)
      begin : g_dma
         assign ch_sel[c] = dma_sel[c];
      end
      else
      begin : g_gen
         assign ch_sel[c] = gen_sel[c-NDMA];
      end
   end

   typedef struct packed
   {
      logic [NCH-1:0] route_evt;
   } top_state_t;

   top_state_t st;
   top_state_t next_st;

   // The selected event is registered once, which keeps the wide select
   // multiplexer out of the handshake timing path at the cost of one cycle.
   always_comb
   begin
      next_st = st;
      for (int c = 0; c < NCH; c++)
      begin
         next_st.route_evt[c] = 1'b0;
         for (int p = 0; p < NPUB; p++)
         begin
            if (ch_sel[c] == SELW'(p + IDX_BASE))
            begin
               next_st.route_evt[c] = pub_evt[p];
            end
         end
      end
   end

   // Route register.
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         st <= '{route_evt: {NCH{TRIG_RESET}}};
      end
      else
      begin
         st <= next_st;
      end
   end

   // ==========================================================================
   // Route channels
   // ==========================================================================
   // DMA channels give a single trigger; generic channels below NSPLIT drive
   // two subscribers with one pulse, the rest only the first subscriber.
   for (genvar c = 0; c < NCH; c++)
   begin : g_ch
      if (c < NDMA)
      begin : g_dma
         route_channel #(
            .SPLIT (1'b0)
         ) u_ch (
            .clk     (clk),
            .rst_n   (rst_n),
            .evt     (st.route_evt[c]),
            .pwr_ack (pwr_ack[c]),
            .pwr_req (pwr_req[c]),
            .trig_a  (dma_trig[c]),
            .trig_b  ()
         );
      end
      else
      begin : g_gen
         route_channel #(
            .SPLIT ((c - NDMA) < NSPLIT)
         ) u_ch (
            .clk     (clk),
            .rst_n   (rst_n),
            .evt     (st.route_evt[c]),
            .pwr_ack (pwr_ack[c]),
            .pwr_req (pwr_req[c]),
            .trig_a  (gen_trig_a[c-NDMA]),
            .trig_b  (gen_trig_b[c-NDMA])
         );
      end
   end

   // ==========================================================================
   // Checks
   // ==========================================================================
   // Helper: bits being cleared with no setter in the same cycle.
   logic [NPUB-1:0][NCOND-1:0] clr_only;

   for (genvar p = 0; p < NPUB; p++)
   begin : g_chk
      assign clr_only[p] = software_event_clear[p] & ~software_event_set[p]
                           & ~hw_cond[p];

      chk_masked_and: assert property (@(posedge clk) disable iff (!rst_n)
         masked_event_status[p] == (raw_event_status[p] & $past(condition_mask[p])))
         else $error("masked status differs from raw AND mask");

      chk_mask_gate: assert property (@(posedge clk) disable iff (!rst_n)
         (condition_mask[p] == '0) |=> !cpu_irq[p] && !pub_evt[p])
         else $error("fully masked publisher still propagated");

      chk_irq_level: assert property (@(posedge clk) disable iff (!rst_n)
         cpu_irq[p] == (|masked_event_status[p]))
         else $error("interrupt line does not follow masked status");

      chk_set_bits: assert property (@(posedge clk) disable iff (!rst_n)
         (software_event_set[p] != '0) |=>
         (raw_event_status[p] & $past(software_event_set[p]))
            == $past(software_event_set[p]))
         else $error("software set did not set raw status");

      chk_clear_bits: assert property (@(posedge clk) disable iff (!rst_n)
         (clr_only[p] != '0) |=> (raw_event_status[p] & $past(clr_only[p])) == '0)
         else $error("software clear did not clear raw status");

      chk_event_emit: assert property (@(posedge clk) disable iff (!rst_n)
         pub_evt[p] == (|(masked_event_status[p] & ~$past(masked_event_status[p]))))
         else $error("event pulse does not match new masked condition");

      chk_index_read: assert property (@(posedge clk) disable iff (!rst_n)
         (index_read[p] && masked_event_status[p][0] && !hw_cond[p][0]
            && !software_event_set[p][0])
         |=> pending_index_reader[p] == IDXW'(IDX_BASE) && !raw_event_status[p][0])
         else $error("index read did not return and clear top condition");
   end

   for (genvar c = 0; c < NCH; c++)
   begin : g_chk_route
      chk_route_select: assert property (@(posedge clk) disable iff (!rst_n)
         (ch_sel[c] == '0) |=> !st.route_evt[c])
         else $error("unselected channel received an event");
   end

endmodule : event_route_manager

// file: test/pwr_clock_model.sv
// ============================================================================
// Power and clock unit model
// ============================================================================
// Purpose: Answers each channel's power request with an acknowledge level.
// Assumes: Requests are levels held until the trigger has gone out.
// Notes:   With slow set, the domain takes SLOW_DLY + 1 cycles to come up.
`timescale 1ns/1ps
module pwr_clock_model
#(
   parameter int N        = 6,
   parameter int SLOW_DLY = 6
)
(
   input  wire logic         clk,
   input  wire logic         rst_n,
   input  wire logic         slow,
   input  wire logic [N-1:0] req,
   output logic      [N-1:0] ack
);
   int cnt [N];

   // Acknowledge tracks the request after a delay; it drops once released.
   always @(posedge clk or negedge rst_n)
   begin
      for (int i = 0; i < N; i++)
      begin
         if (!rst_n || !req[i])
         begin
            ack[i] <= 1'b0;
            cnt[i] <= 0;
         end
         else
         begin
            cnt[i] <= cnt[i] + 1;
            ack[i] <= (cnt[i] >= (slow ? SLOW_DLY : 0));
         end
      end
   end
endmodule : pwr_clock_model

// file: test/tb_top.sv
// ============================================================================
// Event route manager testbench
// ============================================================================
// Purpose: Checks status registers, index reads and the three route kinds.
// Assumes: Default sizes; inputs change at the rising edge by non-blocking.
// Notes:   Outputs are sampled 1 ns after an edge, once its updates landed.
`timescale 1ns/1ps
module tb_top;
   import event_route_pkg::*;
   localparam int SW = $clog2(DEF_NPUB + 1);
   localparam int IW = $clog2(DEF_NCOND + 1);
   logic                                clk = 1'b0;
   logic                                rst_n = 1'b0;
   logic                                slow = 1'b0;
   logic [DEF_NPUB-1:0][DEF_NCOND-1:0]  hw_cond = '0;
   logic [DEF_NPUB-1:0][DEF_NCOND-1:0]  condition_mask = '0;
   logic [DEF_NPUB-1:0][DEF_NCOND-1:0]  software_event_set = '0;
   logic [DEF_NPUB-1:0][DEF_NCOND-1:0]  software_event_clear = '0;
   logic [DEF_NPUB-1:0]                 index_read = '0;
   logic [DEF_NDMA-1:0][SW-1:0]         dma_sel = '0;
   logic [DEF_NGEN-1:0][SW-1:0]         gen_sel = '0;
   logic [5:0]                          pwr_ack;
   logic [5:0]                          pwr_req;
   logic [DEF_NPUB-1:0][DEF_NCOND-1:0]  raw_event_status;
   logic [DEF_NPUB-1:0][DEF_NCOND-1:0]  masked_event_status;
   logic [DEF_NPUB-1:0][IW-1:0]         pending_index_reader;
   logic [DEF_NPUB-1:0]                 cpu_irq;
   logic [1:0]                          dma_trig;
   logic [3:0]                          gen_trig_a;
   logic [3:0]                          gen_trig_b;
   logic [9:0]                          trg;
   int                                  mismatches = 0;
   int                                  checked = 0;

   // All triggers in one vector: split halves high, then first halves, then DMA.
   assign trg = {gen_trig_b, gen_trig_a, dma_trig};

   // Free running 100 MHz clock.
   always #5 clk = ~clk;

   event_route_manager dut (.clk(clk), .rst_n(rst_n), .hw_cond(hw_cond),
      .condition_mask(condition_mask), .software_event_set(software_event_set),
      .software_event_clear(software_event_clear), .index_read(index_read),
      .dma_sel(dma_sel), .gen_sel(gen_sel), .pwr_ack(pwr_ack),
      .raw_event_status(raw_event_status), .masked_event_status(masked_event_status),
      .pending_index_reader(pending_index_reader), .cpu_irq(cpu_irq),
      .dma_trig(dma_trig), .gen_trig_a(gen_trig_a), .gen_trig_b(gen_trig_b),
      .pwr_req(pwr_req));

   pwr_clock_model pcu (.clk(clk), .rst_n(rst_n), .slow(slow), .req(pwr_req),
      .ack(pwr_ack));

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp)
      begin
         mismatches++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic print_verdict;
      $display("checked=%0d mismatches=%0d", checked, mismatches);
      if (mismatches == 0 && checked > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : print_verdict

   // Every output idles low straight after reset.
   task automatic t_reset;
      #1;
      chk(raw_event_status, '0);
      chk(masked_event_status | pending_index_reader, '0);
      chk({cpu_irq, trg, pwr_req}, '0);
   endtask : t_reset

   // A masked-off condition stays in raw only; the unmasked one beside it raises the interrupt.
   task automatic t_mask;
      @(posedge clk);
      condition_mask[0] <= 8'h08;
      hw_cond[0] <= 8'h28;
      @(posedge clk);
      hw_cond[0] <= '0;
      #1;
      chk(raw_event_status[0], 8'h28);
      chk(masked_event_status[0], 8'h08);
      chk(cpu_irq[0], 1'b1);
      @(posedge clk);
      software_event_clear[0] <= 8'hff;
      @(posedge clk);
      software_event_clear[0] <= '0;
      #1;
      chk(raw_event_status[0], 8'h00);
      chk(cpu_irq[0], 1'b0);
   endtask : t_mask

   // Index reads hand out conditions by priority and clear them one by one.
   task automatic t_index;
      logic [7:0] er [4] = '{8'h48, 8'h40, 8'h00, 8'h00};
      logic [3:0] ei [4] = '{4'h1, 4'h4, 4'h7, 4'h0};
      @(posedge clk);
      condition_mask[1] <= 8'hff;
      software_event_set[1] <= 8'h49;
      @(posedge clk);
      software_event_set[1] <= '0;
      #1;
      chk(masked_event_status[1], 8'h49);
      for (int i = 0; i < 4; i++)
      begin
         @(posedge clk);
         index_read[1] <= 1'b1;
         @(posedge clk);
         index_read[1] <= 1'b0;
         #1;
         chk(pending_index_reader[1], ei[i]);
         chk(raw_event_status[1] | masked_event_status[1], er[i]);
      end
      chk(cpu_irq[1], 1'b0);
      // A set and a clear of one bit together: the set wins; a clear of the other bits leaves it set.
      @(posedge clk);
      software_event_set[1] <= 8'h02;
      software_event_clear[1] <= 8'h02;
      @(posedge clk);
      software_event_set[1] <= '0;
      software_event_clear[1] <= 8'hfd;
      #1;
      chk(raw_event_status[1], 8'h02);
      @(posedge clk);
      software_event_clear[1] <= 8'h02;
      #1;
      chk(raw_event_status[1], 8'h02);
      @(posedge clk);
      software_event_clear[1] <= '0;
      #1;
      chk(raw_event_status[1], 8'h00);
   endtask : t_index

   // One event from publisher p must reach exactly the expected triggers.
   task automatic t_route(input int p, input logic [9:0] et, input logic [5:0] er,
                          input bit slw);
      int n = 0;
      bit sr = 1'b0;
      @(posedge clk);
      slow <= slw;
      condition_mask[p] <= 8'hff;
      hw_cond[p] <= 8'h01;
      @(posedge clk);
      hw_cond[p] <= '0;
      #1;
      chk(cpu_irq[p], 1'b1);
      while (trg === '0 && n < 40)
      begin
         if ((pwr_req & er) !== '0)
            sr = 1'b1;
         @(posedge clk);
         #1;
         n++;
      end
      chk(trg, et);
      chk(sr, 1'b1);
      if (slw)
         chk(n >= 7, 1'b1);
      @(posedge clk);
      #1;
      chk({trg, pwr_req & er}, '0);
      @(posedge clk);
      software_event_clear[p] <= 8'hff;
      @(posedge clk);
      software_event_clear[p] <= '0;
   endtask : t_route

   // Hang guard: the whole sequence needs well under 1000 cycles.
   initial
   begin
      #100us;
      mismatches++;
      print_verdict();
   end

   // Main sequence.
   initial
   begin
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      t_reset();
      t_mask();
      t_index();
      @(posedge clk);
      dma_sel <= {3'd2, 3'd1};
      gen_sel <= {3'd5, 3'd4, 3'd0, 3'd3};
      t_route(0, 10'h001, 6'h01, 1'b0);
      t_route(1, 10'h002, 6'h02, 1'b0);
      t_route(2, 10'h044, 6'h04, 1'b0);
      t_route(3, 10'h010, 6'h10, 1'b0);
      t_route(0, 10'h001, 6'h01, 1'b1);
      t_route(2, 10'h044, 6'h04, 1'b1);
      print_verdict();
   end
endmodule : tb_top
